/* File: doc_params.svh */
// Constants for the converter output-state control block.
// Assumes inclusion by bare name from the package, the checker, the host model and the bench.
`ifndef DOC_PARAMS_SVH
`define DOC_PARAMS_SVH

// Register addresses on the plain register port
`define DOC_ADDR_DAC 3'h1
`define DOC_ADDR_CTRL 3'h2
`define DOC_ADDR_CLRCODE 3'h3
`define DOC_ADDR_SWCTRL 3'h4

// Data word layout
`define DOC_DATA_W 20
`define DOC_CODE_W 16
`define DOC_CODE_LSB 4

// Control register bit positions
`define DOC_CTRL_FB_BIT 1
`define DOC_CTRL_CLAMP_BIT 2
`define DOC_CTRL_HIZ_BIT 3
`define DOC_CTRL_FMT_BIT 4
`define DOC_CTRL_SDO_BIT 5

// Software command register bit positions
`define DOC_CMD_LOAD_BIT 0
`define DOC_CMD_CLEAR_BIT 1
`define DOC_CMD_RESET_BIT 2

// Power-on values
`define DOC_RST_CODE 16'h8000
`define DOC_RST_CLRCODE 16'h0000
`define DOC_RST_FB 1'h1
`define DOC_RST_CLAMP 1'h1
`define DOC_RST_HIZ 1'h1
`define DOC_RST_FMT 1'h0
`define DOC_RST_SDO 1'h0

// Idle level of the two active-low command pins
`define DOC_PIN_IDLE 2'h3

`endif

/* File: doc_pkg.sv */
// Types shared by the converter output-state control block.
// Assumes doc_params.svh is on the include path.
package doc_pkg;
  `include "doc_params.svh"

  // Output state of the analog stage, Gray along normal-hiz-clamp
  typedef enum logic [1:0] {
    DOC_OUT_NORMAL = 2'h0,
    DOC_OUT_HIZ = 2'h1,
    DOC_OUT_CLAMP = 2'h3
  } doc_out_t;

  // Code word held by the converter registers
  typedef logic [`DOC_CODE_W-1:0] doc_code_t;

  // Register port data word
  typedef logic [`DOC_DATA_W-1:0] doc_word_t;
endpackage

/* File: doc_sync.sv */
// Two-stage synchroniser for asynchronous pin levels.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module doc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // Both stages of the synchroniser
  typedef struct packed {
    logic [W-1:0] meta; // First stage, read only by the second
    logic [W-1:0] stab; // Second stage, safe to use
  } doc_sync_state_t;

  doc_sync_state_t st_r;
  doc_sync_state_t st_nxt;

  // Shift the pin level through both stages
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = din;
    st_nxt.stab = st_r.meta;
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{meta: RST_VAL, stab: RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.stab;
endmodule // doc_sync

/* File: doc_output_ctrl.sv */
// Output-state and command control of a 16-bit voltage-output converter.
// Assumes one 250 MHz clock, registers reached over a plain strobe port,
// and active-low load and clear pins that arrive asynchronously.
//
// Summary of operation
// - Load command moves pending code to converter
// - Clear command loads the programmed clear code
// - Clear code follows selected code format
// - Reset command restores the power-on state
// - Power-on reset restores every register default
// - Power-on: converter tristated, output ground-clamped
// - Clamped tristate persists until control write
// - Clearing hiz and clamp bits frees output
// - Freed output sits at negative reference level, midscale if offset binary
// - Output state decoded from hiz, clamp bits
// - Command register write-only, mirrors pin pulses
// - Clear command ignored under load pin, and vice versa
`timescale 1ns/1ns
module doc_output_ctrl
  import doc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [`DOC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DOC_DATA_W-1:0] reg_rdata,
  // Asynchronous command pins, active low
  input wire logic load_output_pin_n,
  input wire logic apply_clear_pin_n,
  // Converter code, always offset binary toward the analog core
  output logic [`DOC_CODE_W-1:0] dac_code,
  // Analog stage controls
  output logic [1:0] out_state,
  output logic ref_connect,
  output logic output_ground_clamp,
  output logic converter_hiz_select,
  output logic feedback_resistor_select,
  output logic code_format_select,
  output logic sdo_disable
);

  // All state of the block
  typedef struct packed {
    doc_code_t input_code;   // Pending code, not yet on the output
    doc_code_t dac_reg;      // Active converter register
    doc_code_t clear_code;   // User clear code
    logic fb_sel;            // Feedback resistor select
    logic clamp;             // Ground clamp bit
    logic hiz;               // Converter tristate bit
    logic fmt;               // 1 offset binary, 0 twos complement
    logic sdo_dis;           // Serial data out disable
    doc_code_t dac_code;     // Registered analog code
    doc_out_t out_state;     // Registered output state
    logic ref_connect;       // References connected to the ladder
    doc_word_t rdata;        // Read data, valid one cycle after strobe
  } doc_state_t;

  // Power-on contents, also taken by the software reset
  localparam doc_state_t ST_RST = '{
    input_code: `DOC_RST_CODE,
    dac_reg: `DOC_RST_CODE,
    clear_code: `DOC_RST_CLRCODE,
    fb_sel: `DOC_RST_FB,
    clamp: `DOC_RST_CLAMP,
    hiz: `DOC_RST_HIZ,
    fmt: `DOC_RST_FMT,
    sdo_dis: `DOC_RST_SDO,
    dac_code: 16'h0000,
    out_state: DOC_OUT_CLAMP,
    ref_connect: 1'h0,
    rdata: 20'h00000
  };

  doc_state_t st_r;   // Registered state
  doc_state_t st_nxt; // Next state

  // Synchronised pin levels, bit 1 load, bit 0 clear
  logic [1:0] pins_sync;
  logic load_pin_low;  // Load pin held low
  logic clear_pin_low; // Clear pin held low

  // Decoded register accesses
  logic wr_dac;
  logic wr_ctrl;
  logic wr_clr;
  logic wr_cmd;

  // Command strobes after pin gating
  logic load_cmd;  // load_output_cmd taking effect
  logic clear_cmd; // apply_clear_code_cmd taking effect
  logic reset_cmd; // Software reset taking effect

  // Convert a register code to the offset-binary code of the core
  function automatic doc_code_t to_core(input doc_code_t code, input logic fmt);
    doc_code_t res;
    res = code;
    if (!fmt) begin
      // Twos complement: flip the sign bit
      res[`DOC_CODE_W-1] = ~code[`DOC_CODE_W-1];
    end
    return res;
  endfunction

  // Decode the output state from the two control bits
  function automatic doc_out_t decode_state(input logic hiz, input logic clamp);
    doc_out_t res;
    res = DOC_OUT_NORMAL;
    if (clamp) begin
      // Clamp overrides tristate
      res = DOC_OUT_CLAMP;
    end else if (hiz) begin
      res = DOC_OUT_HIZ;
    end else begin
      res = DOC_OUT_NORMAL;
    end
    return res;
  endfunction

  // Bring both command pins into the clock domain
  doc_sync #(
    .W(2),
    .RST_VAL(`DOC_PIN_IDLE)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .din({load_output_pin_n, apply_clear_pin_n}),
    .dout(pins_sync)
  );

  // Pin levels after synchronisation
  assign load_pin_low = ~pins_sync[1];
  assign clear_pin_low = ~pins_sync[0];

  // Address decode of write strobes
  assign wr_dac = reg_wr && (reg_addr == `DOC_ADDR_DAC);
  assign wr_ctrl = reg_wr && (reg_addr == `DOC_ADDR_CTRL);
  assign wr_clr = reg_wr && (reg_addr == `DOC_ADDR_CLRCODE);
  assign wr_cmd = reg_wr && (reg_addr == `DOC_ADDR_SWCTRL);

  // Command bits act only in the write cycle, nothing is stored
  assign load_cmd = wr_cmd && reg_wdata[`DOC_CMD_LOAD_BIT] && !clear_pin_low;
  assign clear_cmd = wr_cmd && reg_wdata[`DOC_CMD_CLEAR_BIT] && !load_pin_low;
  assign reset_cmd = wr_cmd && reg_wdata[`DOC_CMD_RESET_BIT];

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    // Read data stand for one cycle only
    st_nxt.rdata = '0;

    // Pending code from a data write
    if (wr_dac) begin
      st_nxt.input_code = reg_wdata[`DOC_CODE_LSB +: `DOC_CODE_W];
    end

    // Clear code register
    if (wr_clr) begin
      st_nxt.clear_code = reg_wdata[`DOC_CODE_LSB +: `DOC_CODE_W];
    end

    // Control register: only a write leaves the power-on condition
    if (wr_ctrl) begin
      st_nxt.fb_sel = reg_wdata[`DOC_CTRL_FB_BIT];
      st_nxt.clamp = reg_wdata[`DOC_CTRL_CLAMP_BIT];
      st_nxt.hiz = reg_wdata[`DOC_CTRL_HIZ_BIT];
      st_nxt.fmt = reg_wdata[`DOC_CTRL_FMT_BIT];
      st_nxt.sdo_dis = reg_wdata[`DOC_CTRL_SDO_BIT];
    end

    // Converter register update, clear before load
    if (clear_pin_low || clear_cmd) begin
      // Clear code taken as a raw register word
      st_nxt.dac_reg = st_nxt.clear_code;
    end else if (load_pin_low || load_cmd) begin
      // Pending code, including one written in this cycle
      st_nxt.dac_reg = st_nxt.input_code;
    end

    // Register reads
    if (reg_rd) begin
      case (reg_addr)
        `DOC_ADDR_DAC: begin
          st_nxt.rdata = {st_r.dac_reg, 4'h0};
        end
        `DOC_ADDR_CTRL: begin
          st_nxt.rdata = '0;
          st_nxt.rdata[`DOC_CTRL_FB_BIT] = st_r.fb_sel;
          st_nxt.rdata[`DOC_CTRL_CLAMP_BIT] = st_r.clamp;
          st_nxt.rdata[`DOC_CTRL_HIZ_BIT] = st_r.hiz;
          st_nxt.rdata[`DOC_CTRL_FMT_BIT] = st_r.fmt;
          st_nxt.rdata[`DOC_CTRL_SDO_BIT] = st_r.sdo_dis;
        end
        `DOC_ADDR_CLRCODE: begin
          st_nxt.rdata = {st_r.clear_code, 4'h0};
        end
        default: begin
          // Command register is write-only, unmapped reads give zero
          st_nxt.rdata = '0;
        end
      endcase
    end

    // Software reset returns the whole block to its power-on state
    if (reset_cmd) begin
      st_nxt = ST_RST;
    end

    // Analog code follows the coding selected now
    st_nxt.dac_code = to_core(st_nxt.dac_reg, st_nxt.fmt);

    // Output state and reference switches
    st_nxt.out_state = decode_state(st_nxt.hiz, st_nxt.clamp);
    st_nxt.ref_connect = (st_nxt.out_state == DOC_OUT_NORMAL);
  end

  // State register, power-on defaults under reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs, each straight from the state register
  assign reg_rdata = st_r.rdata;
  assign dac_code = st_r.dac_code;
  assign out_state = st_r.out_state;
  assign ref_connect = st_r.ref_connect;
  assign output_ground_clamp = st_r.clamp;
  assign converter_hiz_select = st_r.hiz;
  // Unity gain with compensation when set, gain of two when clear
  assign feedback_resistor_select = st_r.fb_sel;
  assign code_format_select = st_r.fmt;
  assign sdo_disable = st_r.sdo_dis;

endmodule // doc_output_ctrl

/* File: doc_output_ctrl_monitor.sv */
// Checker for the converter output-state control block.
// Assumes one clock domain, async reset rstn, bound to the top module.
`timescale 1ns/1ns
`include "doc_params.svh"
module doc_output_ctrl_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [`DOC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`DOC_DATA_W-1:0] reg_rdata,
  // Command pins
  input wire logic load_output_pin_n,
  input wire logic apply_clear_pin_n,
  // Analog stage
  input wire logic [`DOC_CODE_W-1:0] dac_code,
  input wire logic [1:0] out_state,
  input wire logic ref_connect,
  input wire logic output_ground_clamp,
  input wire logic converter_hiz_select,
  input wire logic feedback_resistor_select,
  input wire logic code_format_select,
  input wire logic sdo_disable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Writes to control and command places
  wire ctl_wr = reg_wr && reg_addr == 3'h2;
  wire cmd_wr = reg_wr && reg_addr == 3'h4;
  // Recent pin activity, covers the sync delay
  logic [3:0] pin_low_h;
  // Shift in pin activity each cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_low_h <= 4'h0;
    end else begin
      pin_low_h <= {pin_low_h[2:0], !(load_output_pin_n && apply_clear_pin_n)};
    end
  end
  state_decode_a: assert property (
    out_state == (output_ground_clamp ? 2'h3 : (converter_hiz_select ? 2'h1 : 2'h0)))
    else $error("output state decode wrong");
  ref_normal_a: assert property (ref_connect == (out_state == 2'h0))
    else $error("reference connect wrong");
  rdata_idle_a: assert property (
    !$past(reg_rd) || $past(reg_addr) == 3'h4 |-> reg_rdata == '0)
    else $error("read data not zero");
  ctrl_write_a: assert property (ctl_wr |=>
    {converter_hiz_select, output_ground_clamp, feedback_resistor_select}
    == $past(reg_wdata[3:1])) else $error("control bits not taken");
  ctrl_hold_a: assert property (!ctl_wr && !cmd_wr |=> $stable({output_ground_clamp,
    converter_hiz_select, feedback_resistor_select, code_format_select, sdo_disable}))
    else $error("control bits moved");
  sw_reset_a: assert property (cmd_wr && reg_wdata[2] |=> out_state == 2'h3
    && dac_code == '0 && feedback_resistor_select && !code_format_select)
    else $error("reset command wrong");
  fmt_flip_a: assert property (ctl_wr && reg_wdata[4] != code_format_select
    |=> dac_code == ($past(dac_code) ^ 16'h8000)) else $error("format change wrong");
  code_cause_a: assert property ($changed(dac_code) |-> $past(reg_wr) || |pin_low_h)
    else $error("code changed without cause");
endmodule // doc_output_ctrl_monitor

bind doc_output_ctrl doc_output_ctrl_monitor u_mon (.core_clk(core_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .load_output_pin_n(load_output_pin_n),
  .apply_clear_pin_n(apply_clear_pin_n), .dac_code(dac_code), .out_state(out_state),
  .ref_connect(ref_connect), .output_ground_clamp(output_ground_clamp),
  .converter_hiz_select(converter_hiz_select), .sdo_disable(sdo_disable),
  .feedback_resistor_select(feedback_resistor_select),
  .code_format_select(code_format_select));

/* File: doc_host_model.sv */
// Host controller model driving the register port and command pins.
// Assumes the caller runs its tasks from one process.
`timescale 1ns/1ns
`include "doc_params.svh"
module doc_host_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [2:0] reg_addr,
  output logic [`DOC_DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [`DOC_DATA_W-1:0] reg_rdata,
  // Command pins, active low
  output logic load_output_pin_n,
  output logic apply_clear_pin_n
);
  // Idle bus at time zero
  initial begin
    reg_addr = 3'h0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    load_output_pin_n = 1'b1;
    apply_clear_pin_n = 1'b1;
  end
  // One-cycle write; released bus shows the inverse
  task automatic wr(input logic [2:0] a, input logic [`DOC_DATA_W-1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // One-cycle read, data taken in the following cycle
  task automatic rd(input logic [2:0] a, output logic [`DOC_DATA_W-1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
  // Leave clamp and tristate, set gain mode and coding in the same write
  task automatic set_mode(input logic fb, input logic fmt);
    wr(3'h2, {15'h0, fmt, 2'h0, fb, 1'b0});
  endtask
  // Set both command pin levels
  task automatic pins(input logic ld_n, input logic cl_n);
    @(posedge core_clk);
    load_output_pin_n <= ld_n;
    apply_clear_pin_n <= cl_n;
  endtask
endmodule // doc_host_model

/* File: tb_doc_output_ctrl.sv */
// Self-checking bench for the output-state control block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`include "doc_params.svh"
`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin fail_count++; \
  $display("BAD %s exp %0h got %0h", n, e, v); end end
module tb_doc_output_ctrl
  import doc_pkg::*;
;
  logic core_clk, rstn;
  logic [2:0] reg_addr;
  logic [19:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, ld_n, cl_n, ref_c, clamp, hiz, fb, fmt, sdo;
  logic [15:0] dac_code;
  logic [1:0] out_state;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  doc_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .load_output_pin_n(ld_n), .apply_clear_pin_n(cl_n));
  doc_output_ctrl dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .load_output_pin_n(ld_n), .apply_clear_pin_n(cl_n), .dac_code(dac_code),
    .out_state(out_state), .ref_connect(ref_c), .output_ground_clamp(clamp),
    .converter_hiz_select(hiz), .feedback_resistor_select(fb),
    .code_format_select(fmt), .sdo_disable(sdo));
  // Let registered outputs settle
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Power-on state of every output and the control readback
  task automatic chk_por;
    `CHK("state", DOC_OUT_CLAMP, out_state)
    `CHK("ctl", 6'h0E, {sdo, fmt, hiz, clamp, fb, ref_c})
    `CHK("dac", 16'h0000, dac_code)
    host.rd(3'h2, d);
    `CHK("ctrl rd", 20'h0000E, d)
  endtask
  // Power-on hold, unmapped and command reads
  task automatic t_por;
    wait_n(10);
    chk_por();
    host.rd(3'h0, d);
    `CHK("rd 0", 20'h0, d)
    host.rd(3'h4, d);
    `CHK("rd 4", 20'h0, d)
    $display("test por done");
  endtask
  // All four tristate and clamp combinations
  task automatic t_states;
    for (int i = 0; i < 4; i++) begin
      host.wr(3'h2, {16'h0, i[1], i[0], 2'h2});
      wait_n(2);
      `CHK("st", i[0] ? 2'h3 : (i[1] ? 2'h1 : 2'h0), out_state)
      `CHK("ref", i == 0, ref_c)
      `CHK("bits", {i[1], i[0]}, {hiz, clamp})
    end
    host.set_mode(1'b1, 1'b0);
    wait_n(2);
    `CHK("vrefn", 16'h0000, dac_code)
    $display("test states done");
  endtask
  // Load command, then pending write without command
  task automatic t_load;
    host.wr(3'h1, 20'h12340);
    wait_n(2);
    `CHK("pend", 16'h0000, dac_code)
    host.wr(3'h4, 20'h1);
    wait_n(2);
    `CHK("load", 16'h9234, dac_code)
    host.wr(3'h1, 20'hABCD0);
    wait_n(3);
    `CHK("once", 16'h9234, dac_code)
    $display("test load done");
  endtask
  // Clear code under both codings, gain of two
  task automatic t_clear;
    host.wr(3'h3, 20'h0F0F0);
    host.wr(3'h4, 20'h2);
    wait_n(2);
    `CHK("clr", 16'h8F0F, dac_code)
    host.set_mode(1'b0, 1'b1);
    wait_n(2);
    `CHK("clr bin", 16'h0F0F, dac_code)
    `CHK("fb", 1'b0, fb)
    `CHK("fmt", 1'b1, fmt)
    $display("test clear done");
  endtask
  // Commands refused under the opposite pin
  task automatic t_pins;
    host.pins(1'b1, 1'b0);
    host.wr(3'h1, 20'h55550);
    host.wr(3'h4, 20'h1);
    wait_n(5);
    `CHK("ld blk", 16'h0F0F, dac_code)
    host.pins(1'b0, 1'b1);
    wait_n(5);
    `CHK("ld pin", 16'h5555, dac_code)
    host.wr(3'h3, 20'h77770);
    host.wr(3'h4, 20'h2);
    wait_n(3);
    `CHK("cl blk", 16'h5555, dac_code)
    host.pins(1'b1, 1'b1);
    $display("test pins done");
  endtask
  // Unmapped write ignored, then software reset
  task automatic t_swreset;
    host.wr(3'h0, 20'hFFFFE);
    wait_n(5);
    `CHK("unmap", DOC_OUT_NORMAL, out_state)
    host.wr(3'h2, 20'h00020);
    wait_n(2);
    `CHK("sdo", 1'b1, sdo)
    host.wr(3'h4, 20'h4);
    wait_n(2);
    chk_por();
    $display("test swreset done");
  endtask
  // Counts and verdict, end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Free-running clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    rstn = 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    t_por();
    t_states();
    t_load();
    t_clear();
    t_pins();
    t_swreset();
    report_and_stop();
  end
endmodule // tb_doc_output_ctrl
